//--- shared/bmd_defs.svh
// Constants of the byte memory transfer engine.
`ifndef BMD_DEFS_SVH
`define BMD_DEFS_SVH
`define BMD_ADDR_CTRL 8'h00
`define BMD_ADDR_IADDR 8'h04
`define BMD_ADDR_EADDR 8'h08
`define BMD_ADDR_PAGE 8'h0C
`define BMD_ADDR_COUNT 8'h10
`define BMD_ADDR_STATUS 8'h14
`define BMD_CTRL_FMT 1:0
`define BMD_CTRL_DIR 2
`define BMD_CTRL_HOLD 3
`define BMD_CTRL_WAIT 6:4
`define BMD_STAT_BUSY 0
`define BMD_STAT_HALT 1
`define BMD_FMT_PM 2'h0
`define BMD_FMT_DM 2'h1
`define BMD_FMT_MSB 2'h2
`define BMD_FMT_LSB 2'h3
`define BMD_BYTES_PM 2'h3
`define BMD_BYTES_DM 2'h2
`define BMD_BYTES_8 2'h1
`define BMD_WAIT_RESET 3'h7
`define BMD_BOOT_COUNT 14'h0020
`define BMD_SETTLE_CYCLES 2'h2
`define BMD_INIT_CYCLES 2'h2
`endif

//--- shared/bmd_pkg.sv
// Types of the byte memory transfer engine.
package bmd_pkg;
   typedef enum logic [3:0] {
      BMD_IDLE = 4'h0,
      BMD_INIT = 4'h1,
      BMD_FETCH = 4'h2,
      BMD_MEM_WAIT = 4'h3,
      BMD_TAKE = 4'h4,
      BMD_ARB = 4'h5,
      BMD_ACCESS = 4'h6,
      BMD_SETTLE = 4'h7,
      BMD_NEXT_BYTE = 4'h8,
      BMD_STORE = 4'h9,
      BMD_NEXT_WORD = 4'hA,
      BMD_DONE = 4'hB
   } bmd_fsm_type;

   typedef struct packed {
      bmd_fsm_type state;
      logic [1:0] fmt;
      logic dir;
      logic hold;
      logic [2:0] wait_n;
      logic [13:0] iaddr;
      logic [13:0] eaddr;
      logic [7:0] page;
      logic [13:0] count;
      logic [23:0] word;
      logic [1:0] bytes_left;
      logic [1:0] settle;
      logic [1:0] init;
      logic [31:0] prdata;
      logic [7:0] rx_s1;
      logic [7:0] rx_s2;
      logic boot_s1;
      logic boot_s2;
      logic mem_req;
      logic mem_write;
      logic mem_pm;
      logic [13:0] mem_addr;
      logic [23:0] mem_wdata;
      logic halt;
      logic irq;
      logic restart;
   } bmd_main_type;

   typedef struct packed {
      logic [2:0] cnt;
   } bmd_timer_type;
endpackage

//--- design/bmd_wait_timer.sv
// Wait-state down counter that stretches each byte memory strobe.
`timescale 1ns/100ps
`default_nettype none
module bmd_wait_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [2:0] load,
   output logic expired
);
   import bmd_pkg::*;
   bmd_timer_type cur_ff;
   bmd_timer_type nxt_cur;

   // The counter loads at the grant edge and runs down once per cycle.
   always_comb begin
      nxt_cur = cur_ff;
      if (start) begin
         nxt_cur.cnt = load;
      end else if (cur_ff.cnt != 3'h0) begin
         nxt_cur.cnt = cur_ff.cnt - 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign expired = (cur_ff.cnt == 3'h0);
endmodule
`default_nettype wire

//--- design/bmd_byte_memory_dma.sv
// Byte memory transfer engine with its APB register file.
//
// Overview of operation
// - Byte space is 256 pages of 16K bytes each.
// - Each byte travels on external data lines 15 down to 8.
// - Page goes on data lines 23:16, offset on address 13:0.
// - Every byte access is stretched by the programmed wait states.
// - Engine runs beside the core, one core cycle per word.
// - Format 00 program 24-bit, 01 data 16-bit, 10 upper byte, 11 lower.
// - Each word takes as many byte accesses as its size needs.
// - Eight-bit formats fill unused data word bits with zeros.
// - Internal start address gives the first on-chip location.
// - Byte start comes from the offset and start page registers.
// - Direction picks byte-to-chip or chip-to-byte movement.
// - Writing a nonzero word count starts accesses until count reaches zero.
// - Word count updates after every word to show progress.
// - Count at zero finishes the transfer and raises the done request.
// - Offset carries into page so transfers cross page boundaries.
// - On-chip end is always internal program or data memory.
// - A completed word moves to or from on-chip memory in one cycle.
// - Core external accesses win; the byte access waits.
// - Hold bit at 0 lets the core run during transfers.
// - Hold bit at 1 halts the core, then restarts it at 0.
// - Boot selection loads zero addresses, page, format and direction, count 32 and hold set; wait states stay 7.
`timescale 1ns/100ps
`default_nettype none
`include "bmd_defs.svh"
module bmd_byte_memory_dma (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_select,
   input wire logic core_ext_request,
   output logic core_hold,
   output logic core_restart,
   output logic done_irq,
   output logic [13:0] ext_addr,
   output logic [7:0] ext_page_out,
   output logic ext_bus_oe,
   input wire logic [7:0] ext_byte_in,
   output logic [7:0] ext_byte_out,
   output logic ext_byte_oe,
   output logic byte_select_n,
   output logic rd_n,
   output logic wr_n,
   output logic mem_req,
   output logic mem_write,
   output logic mem_program,
   output logic [13:0] mem_addr,
   output logic [23:0] mem_wdata,
   input wire logic [23:0] mem_rdata
);
   import bmd_pkg::*;
   bmd_main_type cur_ff;
   bmd_main_type nxt_cur;
   logic timer_start;
   logic timer_expired;
   logic busy;
   logic strobe;
   logic apb_write;
   logic apb_unmapped;
   logic apb_refused;
   logic [31:0] read_mux;

   function automatic logic [1:0] bmd_bytes(input logic [1:0] fmt);
      case (fmt)
         `BMD_FMT_PM: bmd_bytes = `BMD_BYTES_PM;
         `BMD_FMT_DM: bmd_bytes = `BMD_BYTES_DM;
         default: bmd_bytes = `BMD_BYTES_8;
      endcase
   endfunction

   bmd_wait_timer u_wait (
      .pclk(pclk),
      .presetn(presetn),
      .start(timer_start),
      .load(cur_ff.wait_n),
      .expired(timer_expired)
   );

   assign busy = (cur_ff.state != BMD_IDLE);
   assign strobe = (cur_ff.state == BMD_ACCESS) || (cur_ff.state == BMD_SETTLE);
   assign timer_start = (cur_ff.state == BMD_ARB) && !core_ext_request;
   assign apb_write = psel && penable && pwrite;
   assign apb_unmapped = (paddr != `BMD_ADDR_CTRL) && (paddr != `BMD_ADDR_IADDR) &&
      (paddr != `BMD_ADDR_EADDR) && (paddr != `BMD_ADDR_PAGE) &&
      (paddr != `BMD_ADDR_COUNT) && (paddr != `BMD_ADDR_STATUS);
   assign apb_refused = pwrite && (busy || (paddr == `BMD_ADDR_STATUS));

   // Register read multiplexer; the word count shows live progress.
   always_comb begin
      read_mux = 32'h0000_0000;
      case (paddr)
         `BMD_ADDR_CTRL: begin
            read_mux[`BMD_CTRL_FMT] = cur_ff.fmt;
            read_mux[`BMD_CTRL_DIR] = cur_ff.dir;
            read_mux[`BMD_CTRL_HOLD] = cur_ff.hold;
            read_mux[`BMD_CTRL_WAIT] = cur_ff.wait_n;
         end
         `BMD_ADDR_IADDR: read_mux[13:0] = cur_ff.iaddr;
         `BMD_ADDR_EADDR: read_mux[13:0] = cur_ff.eaddr;
         `BMD_ADDR_PAGE: read_mux[7:0] = cur_ff.page;
         `BMD_ADDR_COUNT: read_mux[13:0] = cur_ff.count;
         `BMD_ADDR_STATUS: begin
            read_mux[`BMD_STAT_BUSY] = busy;
            read_mux[`BMD_STAT_HALT] = cur_ff.halt;
         end
         default: read_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.rx_s1 = ext_byte_in;
      nxt_cur.rx_s2 = cur_ff.rx_s1;
      nxt_cur.boot_s1 = boot_select;
      nxt_cur.boot_s2 = cur_ff.boot_s1;
      nxt_cur.mem_req = 1'b0;
      nxt_cur.irq = 1'b0;
      nxt_cur.restart = 1'b0;
      if (psel && !penable) begin
         nxt_cur.prdata = read_mux;
      end
      case (cur_ff.state)
         BMD_INIT: begin
            if (cur_ff.init == `BMD_INIT_CYCLES) begin
               if (cur_ff.boot_s2) begin
                  nxt_cur.dir = 1'b0;
                  nxt_cur.page = '0;
                  nxt_cur.iaddr = '0;
                  nxt_cur.eaddr = '0;
                  nxt_cur.fmt = `BMD_FMT_PM;
                  nxt_cur.count = `BMD_BOOT_COUNT;
                  nxt_cur.hold = 1'b1;
                  nxt_cur.halt = 1'b1;
                  nxt_cur.bytes_left = `BMD_BYTES_PM;
                  nxt_cur.state = BMD_ARB;
               end else begin
                  nxt_cur.state = BMD_IDLE;
               end
            end else begin
               nxt_cur.init = cur_ff.init + 2'h1;
            end
         end
         BMD_IDLE: begin
            if (apb_write && !apb_refused) begin
               case (paddr)
                  `BMD_ADDR_CTRL: begin
                     nxt_cur.fmt = pwdata[`BMD_CTRL_FMT];
                     nxt_cur.dir = pwdata[`BMD_CTRL_DIR];
                     nxt_cur.hold = pwdata[`BMD_CTRL_HOLD];
                     nxt_cur.wait_n = pwdata[`BMD_CTRL_WAIT];
                  end
                  `BMD_ADDR_IADDR: nxt_cur.iaddr = pwdata[13:0];
                  `BMD_ADDR_EADDR: nxt_cur.eaddr = pwdata[13:0];
                  `BMD_ADDR_PAGE: nxt_cur.page = pwdata[7:0];
                  `BMD_ADDR_COUNT: begin
                     nxt_cur.count = pwdata[13:0];
                     if (pwdata[13:0] != 14'h0000) begin
                        nxt_cur.halt = cur_ff.hold;
                        nxt_cur.bytes_left = bmd_bytes(cur_ff.fmt);
                        nxt_cur.state = cur_ff.dir ? BMD_FETCH : BMD_ARB;
                     end
                  end
                  default: nxt_cur.state = BMD_IDLE;
               endcase
            end
         end
         BMD_FETCH: begin
            nxt_cur.mem_req = 1'b1;
            nxt_cur.mem_write = 1'b0;
            nxt_cur.mem_pm = (cur_ff.fmt == `BMD_FMT_PM);
            nxt_cur.mem_addr = cur_ff.iaddr;
            nxt_cur.state = BMD_MEM_WAIT;
         end
         BMD_MEM_WAIT: nxt_cur.state = BMD_TAKE;
         BMD_TAKE: begin
            case (cur_ff.fmt)
               `BMD_FMT_PM: nxt_cur.word = mem_rdata;
               `BMD_FMT_DM: nxt_cur.word = {mem_rdata[15:0], 8'h00};
               `BMD_FMT_MSB: nxt_cur.word = {mem_rdata[15:8], 16'h0000};
               default: nxt_cur.word = {mem_rdata[7:0], 16'h0000};
            endcase
            nxt_cur.bytes_left = bmd_bytes(cur_ff.fmt);
            nxt_cur.state = BMD_ARB;
         end
         BMD_ARB: begin
            if (!core_ext_request) begin
               nxt_cur.state = BMD_ACCESS;
            end
         end
         BMD_ACCESS: begin
            if (timer_expired) begin
               nxt_cur.settle = 2'h1;
               nxt_cur.state = BMD_SETTLE;
            end
         end
         BMD_SETTLE: begin
            if (cur_ff.settle == `BMD_SETTLE_CYCLES) begin
               if (!cur_ff.dir) begin
                  nxt_cur.word = {cur_ff.word[15:0], cur_ff.rx_s2};
               end
               nxt_cur.state = BMD_NEXT_BYTE;
            end else begin
               nxt_cur.settle = cur_ff.settle + 2'h1;
            end
         end
         BMD_NEXT_BYTE: begin
            {nxt_cur.page, nxt_cur.eaddr} = {cur_ff.page, cur_ff.eaddr} + 22'h000001;
            nxt_cur.bytes_left = cur_ff.bytes_left - 2'h1;
            if (cur_ff.dir) begin
               nxt_cur.word = {cur_ff.word[15:0], 8'h00};
            end
            if (cur_ff.bytes_left == `BMD_BYTES_8) begin
               nxt_cur.state = cur_ff.dir ? BMD_NEXT_WORD : BMD_STORE;
            end else begin
               nxt_cur.state = BMD_ARB;
            end
         end
         BMD_STORE: begin
            nxt_cur.mem_req = 1'b1;
            nxt_cur.mem_write = 1'b1;
            nxt_cur.mem_pm = (cur_ff.fmt == `BMD_FMT_PM);
            nxt_cur.mem_addr = cur_ff.iaddr;
            case (cur_ff.fmt)
               `BMD_FMT_PM: nxt_cur.mem_wdata = cur_ff.word;
               `BMD_FMT_DM: nxt_cur.mem_wdata = {8'h00, cur_ff.word[15:0]};
               `BMD_FMT_MSB: nxt_cur.mem_wdata = {8'h00, cur_ff.word[7:0], 8'h00};
               default: nxt_cur.mem_wdata = {16'h0000, cur_ff.word[7:0]};
            endcase
            nxt_cur.state = BMD_NEXT_WORD;
         end
         BMD_NEXT_WORD: begin
            nxt_cur.iaddr = cur_ff.iaddr + 14'h0001;
            nxt_cur.count = cur_ff.count - 14'h0001;
            nxt_cur.bytes_left = bmd_bytes(cur_ff.fmt);
            if (cur_ff.count == 14'h0001) begin
               nxt_cur.state = BMD_DONE;
            end else begin
               nxt_cur.state = cur_ff.dir ? BMD_FETCH : BMD_ARB;
            end
         end
         BMD_DONE: begin
            nxt_cur.irq = 1'b1;
            nxt_cur.restart = cur_ff.halt;
            nxt_cur.halt = 1'b0;
            nxt_cur.state = BMD_IDLE;
         end
         default: nxt_cur.state = BMD_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff <= '0;
         cur_ff.state <= BMD_INIT;
         cur_ff.wait_n <= `BMD_WAIT_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign prdata = cur_ff.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && (apb_unmapped || apb_refused);
   assign core_hold = cur_ff.halt;
   assign core_restart = cur_ff.restart;
   assign done_irq = cur_ff.irq;
   assign ext_addr = cur_ff.eaddr;
   assign ext_page_out = cur_ff.page;
   assign ext_bus_oe = strobe;
   assign ext_byte_out = cur_ff.word[23:16];
   assign ext_byte_oe = strobe && cur_ff.dir;
   assign byte_select_n = !strobe;
   assign rd_n = !(strobe && !cur_ff.dir);
   assign wr_n = !(strobe && cur_ff.dir);
   assign mem_req = cur_ff.mem_req;
   assign mem_write = cur_ff.mem_write;
   assign mem_program = cur_ff.mem_pm;
   assign mem_addr = cur_ff.mem_addr;
   assign mem_wdata = cur_ff.mem_wdata;

   // Helper counter of strobe length for the checks below.
   logic [3:0] strobe_len_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_len_ff <= 4'h0;
      end else if (strobe) begin
         strobe_len_ff <= strobe_len_ff + 4'h1;
      end else begin
         strobe_len_ff <= 4'h0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_grant;
      (cur_ff.state == BMD_ARB) && !core_ext_request ##1 (cur_ff.state == BMD_ACCESS);
   endsequence
   property p_grant_strobe;
      s_grant |-> !byte_select_n;
   endproperty
   a_grant_strobe: assert property (p_grant_strobe) else $error("Strobe missing.");
   property p_core_wins;
      (cur_ff.state == BMD_ARB) && core_ext_request |=> byte_select_n;
   endproperty
   a_core_wins: assert property (p_core_wins) else $error("Core lost priority.");
   property p_stretch;
      $rose(byte_select_n) |-> strobe_len_ff ==
         4'({1'b0, cur_ff.wait_n}) + 4'(`BMD_SETTLE_CYCLES) + 4'h1;
   endproperty
   a_stretch: assert property (p_stretch) else $error("Wrong strobe length.");
   property p_count_step;
      cur_ff.state == BMD_NEXT_WORD |=> cur_ff.count == $past(cur_ff.count) - 14'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("Count step wrong.");
   property p_irq_once;
      done_irq |-> cur_ff.count == 14'h0000 ##1 !done_irq;
   endproperty
   a_irq_once: assert property (p_irq_once) else $error("Done pulse wrong.");
   property p_page_carry;
      cur_ff.state == BMD_NEXT_BYTE && cur_ff.eaddr == 14'h3FFF |=>
         cur_ff.eaddr == 14'h0000 && cur_ff.page == $past(cur_ff.page) + 8'h01;
   endproperty
   a_page_carry: assert property (p_page_carry) else $error("Page carry lost.");
   property p_zero_fill;
      mem_req && mem_write && !mem_program |-> mem_wdata[23:16] == 8'h00;
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("Unused bits not zero.");
   property p_one_cycle;
      mem_req |=> !mem_req;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("Memory cycle too long.");
   property p_page_drive;
      !byte_select_n ##1 !byte_select_n |->
         $stable(ext_addr) && $stable(ext_page_out) && ext_bus_oe;
   endproperty
   a_page_drive: assert property (p_page_drive) else $error("Address not driven.");
   property p_restart;
      core_restart |-> $past(core_hold) && !core_hold;
   endproperty
   a_restart: assert property (p_restart) else $error("Restart without hold.");
endmodule
`default_nettype wire

//--- testbench/bmd_byte_memory_model.sv
// Behavioural byte-wide external memory at the far side of the transfer engine.
`timescale 1ns/100ps
`default_nettype none
module bmd_byte_memory_model (
   input wire logic pclk,
   input wire logic byte_select_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [13:0] ext_addr,
   input wire logic [7:0] ext_page_out,
   input wire logic [7:0] ext_byte_out,
   input wire logic ext_byte_oe,
   output logic [7:0] ext_byte_in
);
   logic [7:0] store [0:1023];
   logic [21:0] tag [0:1023];
   logic [7:0] last = 8'h00;
   logic [21:0] loc;
   assign loc = {ext_page_out, ext_addr};
   // Written bytes sit in a small tagged table, so writes must not share a slot.
   function automatic logic [9:0] slot(input logic [21:0] a);
      return {a[15:14], a[7:0]};
   endfunction
   // Unwritten locations hold a pattern of the low offset byte and page bits 7:2, so each run of four pages shares it.
   function automatic logic [7:0] peek(input logic [21:0] a);
      if (tag[slot(a)] === a) return store[slot(a)];
      return a[7:0] ^ {2'h0, a[21:16]} ^ 8'hA5;
   endfunction
   always @(posedge pclk) begin
      if (byte_select_n === 1'b0 && wr_n === 1'b0) begin
         store[slot(loc)] = ext_byte_out;
         tag[slot(loc)] = loc;
      end
      if (byte_select_n === 1'b0 && rd_n === 1'b0) last <= peek(loc);
   end
   // Outside any strobe the line shows the inverse of the last byte read; in a write strobe it echoes the driven byte.
   always @* begin
      if (ext_byte_oe === 1'b1) ext_byte_in = ext_byte_out;
      else if (byte_select_n === 1'b0 && rd_n === 1'b0) ext_byte_in = peek(loc);
      else ext_byte_in = ~last;
   end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of the byte memory transfer engine.
`timescale 1ns/100ps
`default_nettype none
`include "bmd_defs.svh"
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, boot_select = 1'b1;
   logic [31:0] pwdata = 32'h0;
   logic core_ext_request = 1'b0;
   logic storm = 1'b0;
   logic [23:0] mem_rdata = 24'h0;
   logic [31:0] prdata;
   logic pready, pslverr, core_hold, core_restart, done_irq, ext_bus_oe, ext_byte_oe;
   logic byte_select_n, rd_n, wr_n, mem_req, mem_write, mem_program;
   logic [13:0] ext_addr, mem_addr;
   logic [7:0] ext_page_out, ext_byte_in, ext_byte_out;
   logic [23:0] mem_wdata;
   logic [23:0] pm [0:127];
   logic [23:0] dm [0:127];
   logic [1:0] cur_fmt = 2'h0;
   logic [2:0] cur_wait = 3'h7;
   logic cur_dir = 1'b0;
   logic req_q = 1'b0;
   int n_errors = 0, total_checks = 0;
   int n_done = 0, n_restart = 0, n_hold = 0, n_req = 0, slen = 0, cyc = 0;
   int d0 = 0, r0 = 0, h0 = 0, q0 = 0;

   always #2.5 pclk = ~pclk;

   bmd_byte_memory_dma u_bmd_byte_memory_dma (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boot_select(boot_select),
      .core_ext_request(core_ext_request), .core_hold(core_hold), .core_restart(core_restart),
      .done_irq(done_irq), .ext_addr(ext_addr), .ext_page_out(ext_page_out),
      .ext_bus_oe(ext_bus_oe), .ext_byte_in(ext_byte_in), .ext_byte_out(ext_byte_out),
      .ext_byte_oe(ext_byte_oe), .byte_select_n(byte_select_n), .rd_n(rd_n), .wr_n(wr_n),
      .mem_req(mem_req), .mem_write(mem_write), .mem_program(mem_program),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   bmd_byte_memory_model u_bmd_byte_memory_model (.pclk(pclk), .byte_select_n(byte_select_n),
      .rd_n(rd_n), .wr_n(wr_n), .ext_addr(ext_addr), .ext_page_out(ext_page_out),
      .ext_byte_out(ext_byte_out), .ext_byte_oe(ext_byte_oe), .ext_byte_in(ext_byte_in));

   task automatic summarize;
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         n_errors++;
      end
   endtask

   task automatic tmo;
      $display("Error at %0t: wait timed out", $time);
      n_errors++;
      summarize();
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) tmo();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] q;
      logic e;
      apb(a, 1'b1, d, q, e);
      check(32'(e), 32'(ee));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      apb(a, 1'b0, 32'h0, q, e);
      check(q, x);
      check(32'(e), 32'(a > `BMD_ADDR_STATUS));
   endtask

   function automatic int nb(input logic [1:0] f);
      return (f == `BMD_FMT_PM) ? 3 : (f == `BMD_FMT_DM) ? 2 : 1;
   endfunction

   task automatic snap;
      d0 = n_done;
      r0 = n_restart;
      h0 = n_hold;
      q0 = n_req;
   endtask

   // Waits for completion, then compares on-chip words with the byte memory contents.
   task automatic fin(input logic [1:0] f, input logic hold, input logic [21:0] s,
         input logic [13:0] ia, input int cnt);
      int i, w, j;
      logic [21:0] a;
      logic [23:0] x, v;
      logic [7:0] b;
      i = 0;
      while (n_done == d0 && i < 20000) begin
         @(posedge pclk);
         i++;
      end
      if (i >= 20000) tmo();
      repeat (3) @(posedge pclk);
      check(n_done - d0, 1);
      check(n_restart - r0, 32'(hold));
      check(32'(n_hold > h0), 32'(hold));
      check(n_req - q0, cnt);
      check(32'(core_hold), 32'h0);
      rd(`BMD_ADDR_COUNT, 32'h0);
      a = s + 22'(nb(f) * cnt);
      rd(`BMD_ADDR_EADDR, 32'(a[13:0]));
      rd(`BMD_ADDR_PAGE, 32'(a[21:14]));
      rd(`BMD_ADDR_IADDR, 32'(ia + 14'(cnt)));
      a = s;
      for (w = 0; w < cnt; w++) begin
         v = (f == `BMD_FMT_PM) ? pm[7'(ia + w)] : dm[7'(ia + w)];
         x = 24'h0;
         for (j = 0; j < nb(f); j++) begin
            b = u_bmd_byte_memory_model.peek(a);
            if (f < 2) x = {x[15:0], b};
            else x = (f == `BMD_FMT_MSB) ? {8'h0, b, 8'h0} : {16'h0, b};
            a++;
         end
         check(32'(x), 32'(v));
      end
   endtask

   task automatic go(input logic [1:0] f, input logic dir, input logic [2:0] ws,
         input logic hold, input logic [21:0] s, input logic [13:0] ia, input int cnt);
      cur_fmt = f;
      cur_dir = dir;
      cur_wait = ws;
      snap();
      wr(`BMD_ADDR_CTRL, {25'h0, ws, hold, dir, f}, 1'b0);
      wr(`BMD_ADDR_IADDR, 32'(ia), 1'b0);
      wr(`BMD_ADDR_EADDR, 32'(s[13:0]), 1'b0);
      wr(`BMD_ADDR_PAGE, 32'(s[21:14]), 1'b0);
      wr(`BMD_ADDR_COUNT, 32'(cnt), 1'b0);
      rd(`BMD_ADDR_STATUS, {30'h0, hold, 1'b1});
      wr(`BMD_ADDR_PAGE, 32'h0, 1'b1);
      fin(f, hold, s, ia, cnt);
   endtask

   // On-chip memory, core bus traffic and byte strobe observation.
   always @(posedge pclk) begin
      cyc++;
      core_ext_request <= storm && (cyc % 7 < 4);
      req_q <= core_ext_request;
      if (done_irq === 1'b1) n_done++;
      if (core_restart === 1'b1) n_restart++;
      if (core_hold === 1'b1) n_hold++;
      if (mem_req === 1'b1) begin
         n_req++;
         check(32'(mem_program), 32'(cur_fmt == `BMD_FMT_PM));
         if (mem_write === 1'b1 && mem_program === 1'b1) pm[mem_addr[6:0]] <= mem_wdata;
         if (mem_write === 1'b1 && mem_program === 1'b0) dm[mem_addr[6:0]] <= mem_wdata;
         mem_rdata <= (mem_program === 1'b1) ? pm[mem_addr[6:0]] : dm[mem_addr[6:0]];
      end
      if (byte_select_n === 1'b0) begin
         if (slen == 0) check(32'(req_q), 32'h0);
         check({28'h0, rd_n, wr_n, ext_bus_oe, ext_byte_oe}, cur_dir ? 32'hB : 32'h6);
         slen++;
      end else if (slen != 0) begin
         check(slen, cur_wait + 3);
         slen = 0;
      end
   end

   initial begin
      int i, k;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      i = 0;
      while (n_req == 0 && i < 5000) begin
         @(posedge pclk);
         i++;
      end
      if (i >= 5000) tmo();
      repeat (4) @(posedge pclk);
      rd(`BMD_ADDR_COUNT, 32'd31);
      fin(`BMD_FMT_PM, 1'b1, 22'h0, 14'h0, 32);
      rd(`BMD_ADDR_CTRL, 32'h78);
      boot_select <= 1'b0;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      for (k = 0; k < 7; k++) rd(8'(4 * k), (k == 0) ? 32'h70 : 32'h0);
      wr(`BMD_ADDR_STATUS, 32'h1, 1'b1);
      go(`BMD_FMT_LSB, 1'b0, 3'h0, 1'b0, {8'h03, 14'h3FFF}, 14'd5, 2);
      go(`BMD_FMT_MSB, 1'b0, 3'h2, 1'b1, {8'h10, 14'h0100}, 14'd20, 2);
      go(`BMD_FMT_DM, 1'b0, 3'h1, 1'b0, {8'h20, 14'h0000}, 14'd30, 3);
      for (k = 0; k < 3; k++) dm[40 + k] = 24'h00C3D4 + 24'(k * 273);
      for (k = 0; k < 2; k++) pm[50 + k] = 24'hE1F203 ^ 24'(k * 4369);
      storm = 1'b1;
      go(`BMD_FMT_DM, 1'b1, 3'h3, 1'b0, {8'h40, 14'h0000}, 14'd40, 3);
      storm = 1'b0;
      dm[60] = 24'h00005A;
      dm[61] = 24'h00A700;
      go(`BMD_FMT_LSB, 1'b1, 3'h1, 1'b0, {8'h40, 14'h0010}, 14'd60, 1);
      go(`BMD_FMT_MSB, 1'b1, 3'h2, 1'b1, {8'h40, 14'h0011}, 14'd61, 1);
      go(`BMD_FMT_PM, 1'b1, 3'h0, 1'b1, {8'h41, 14'h3FFE}, 14'd50, 2);
      summarize();
   end
endmodule
`default_nettype wire
